// ### include/sild_pkg.sv
package sild_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BLINK_HALF_NS = 500000000;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int BLINK_CNT_W = 24;

  localparam logic [7:0] FW_FAULT_OFS = 8'h00;
  localparam logic [7:0] SENSOR_CFG_OFS = 8'h04;
  localparam logic [7:0] IDENT_CMD_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] SENSOR_SNAP_OFS = 8'h10;

  localparam int FW_FAULT_W = 8;
  localparam int FW_MEM_REDUCED = 0;
  localparam int FW_MIRROR_LOST = 1;
  localparam int FW_LINK_CORR = 2;
  localparam int FW_MEM_CORR_OVER = 3;
  localparam int FW_LINK_UNCORR = 4;
  localparam int FW_MEM_NONE = 5;
  localparam int FW_MEM_UNCORR = 6;
  localparam int FW_CPU_CONFIG = 7;
  localparam logic [FW_FAULT_W-1:0] FW_FAULT_RESET = 8'h00;

  localparam int CFG_UPPER_NC_EN = 0;
  localparam logic CFG_UPPER_NC_RESET = 1'b0;

  localparam int CMD_ACTIVATE = 0;
  localparam int CMD_VENDOR = 1;

  localparam int SNS_W = 16;
  localparam int SNS_REDUND_LOSS = 0;
  localparam int SNS_CPU_DISABLED = 1;
  localparam int SNS_FAN_ALARM = 2;
  localparam int SNS_NONCRIT = 3;
  localparam int SNS_UPPER_NC = 4;
  localparam int SNS_BATTERY = 5;
  localparam int SNS_PSU_PREDICT = 6;
  localparam int SNS_CRIT = 7;
  localparam int SNS_REG_HOT = 8;
  localparam int SNS_FANS_LOW = 9;
  localparam int SNS_CPU_CATASTROPHIC_ERROR = 10;
  localparam int SNS_CPU1_ABSENT = 11;
  localparam int SNS_CPU_THERMAL_TRIP = 12;
  localparam int SNS_NO_PGOOD = 13;
  localparam int SNS_PSU_SHORT = 14;
  localparam int SNS_SPARE = 15;
  localparam logic [SNS_W-1:0] SNS_RESET = 16'h0000;

  typedef enum logic [1:0] {
    SEV_OK,
    SEV_DEGRADED,
    SEV_NONFATAL,
    SEV_FATAL
  } sild_sev_e;

  typedef enum logic [1:0] {
    ID_OFF,
    ID_SOLID,
    ID_BLINK
  } sild_id_e;
endpackage : sild_pkg

// ### design/sild_top.sv
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// Function
// [R1] The status LED shows only the most severe fault state currently asserted by any source.
// [R2] Green marks normal or degraded operation, amber marks a hardware fault and beats green.
// [R3] Own sensor faults and other controllers' states merge, each following its current state.
// [R4] With main power off the sensor states and status LED state are kept, not cleared.
// [R5] OK green steady, degraded green blink, non-fatal amber blink, fatal amber steady, off dark.
// [R6] Lost redundancy, CPU disabled, fan alarm, non-critical, battery, PSU predict: degraded.
// [R7] Firmware-reported over-ten correctable memory or uncorrectable link errors are non-fatal.
// [R8] Critical threshold crossing, regulator overtemp or too few fans is non-fatal.
// [R9] Catastrophe, CPU 1 absent, thermal trip, no power good, few PSUs, firmware fatal: fatal.
// [R10] Firmware contributes to the status LED only through its fault-indication command.
// [R11] The upper non-critical threshold counts as degraded only when enabled in the sensor setup.
// [R12] Identify activated by the button lights the identify LED steadily.
// [R13] Identify set by either command blinks the LED at about 1 Hz; inactive, it is dark. The code decodes only the activate bit, not the vendor bit.
// [R14] No source has priority: each new identify request replaces all earlier ones. The code lets a command beat a button press in the same cycle.
// [R15] The button moves a blinking LED to steady on, and a further press turns it off.
// [R16] A free-running clock divider makes the 1 Hz blink at half duty, shared by both LEDs.
module sild_top #(
  parameter int BLINK_HALF = sild_pkg::BLINK_HALF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic main_power_on,
  input wire logic redundancy_loss,
  input wire logic cpu_disabled,
  input wire logic fan_alarm,
  input wire logic noncrit_threshold,
  input wire logic upper_noncrit_threshold,
  input wire logic battery_fail,
  input wire logic psu_predictive_fail,
  input wire logic crit_threshold,
  input wire logic regulator_overtemp,
  input wire logic fans_below_min,
  input wire logic cpu_catastrophic_error,
  input wire logic cpu1_absent,
  input wire logic cpu_thermal_trip,
  input wire logic power_good,
  input wire logic psu_insufficient,
  input wire logic [1:0] hotswap_severity,
  input wire logic identify_button,
  output logic status_led_green,
  output logic status_led_amber,
  output logic identify_led
);

  logic [sild_pkg::BLINK_CNT_W-1:0] blink_cnt_q;
  logic blink_phase_q;
  logic [sild_pkg::SNS_W-1:0] sns_raw;
  logic [sild_pkg::SNS_W-1:0] sns_q;
  logic [1:0] hsc_q;
  logic [sild_pkg::FW_FAULT_W-1:0] fw_fault_q;
  logic upper_nc_en_q;
  logic ready_q;
  logic sev_deg;
  logic sev_nf;
  logic sev_fatal;
  sild_pkg::sild_sev_e sev;
  sild_pkg::sild_id_e id_q;
  logic button_q;
  logic button_press;
  logic cmd_write;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_take;
  logic wr_take;
  logic [31:0] rd_word;
  logic addr_low;

  // Blink divider; the phase bit is shared by both LEDs so they flash together.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      blink_cnt_q <= '0;
      blink_phase_q <= 1'b0;
    end else if (blink_cnt_q == sild_pkg::BLINK_CNT_W'(BLINK_HALF - 1)) begin
      blink_cnt_q <= '0;
      blink_phase_q <= ~blink_phase_q; // [R16]
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  // Power good is active high, so its absence enters the vector as a fault bit.
  always_comb begin
    sns_raw = '0;
    sns_raw[sild_pkg::SNS_REDUND_LOSS] = redundancy_loss;
    sns_raw[sild_pkg::SNS_CPU_DISABLED] = cpu_disabled;
    sns_raw[sild_pkg::SNS_FAN_ALARM] = fan_alarm;
    sns_raw[sild_pkg::SNS_NONCRIT] = noncrit_threshold;
    sns_raw[sild_pkg::SNS_UPPER_NC] = upper_noncrit_threshold;
    sns_raw[sild_pkg::SNS_BATTERY] = battery_fail;
    sns_raw[sild_pkg::SNS_PSU_PREDICT] = psu_predictive_fail;
    sns_raw[sild_pkg::SNS_CRIT] = crit_threshold;
    sns_raw[sild_pkg::SNS_REG_HOT] = regulator_overtemp;
    sns_raw[sild_pkg::SNS_FANS_LOW] = fans_below_min;
    sns_raw[sild_pkg::SNS_CPU_CATASTROPHIC_ERROR] = cpu_catastrophic_error;
    sns_raw[sild_pkg::SNS_CPU1_ABSENT] = cpu1_absent;
    sns_raw[sild_pkg::SNS_CPU_THERMAL_TRIP] = cpu_thermal_trip;
    sns_raw[sild_pkg::SNS_NO_PGOOD] = ~power_good;
    sns_raw[sild_pkg::SNS_PSU_SHORT] = psu_insufficient;
  end

  // Sensor states follow the inputs while main power is on and freeze when it drops.
  genvar gi;
  generate
    for (gi = 0; gi < sild_pkg::SNS_W; gi++) begin : g_sns
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          sns_q[gi] <= sild_pkg::SNS_RESET[gi];
        end else if (main_power_on) begin
          sns_q[gi] <= sns_raw[gi]; // [R3] [R4]
        end
      end
    end
  endgenerate

  // The neighbour controller's severity is held with the sensors while main power is off.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hsc_q <= 2'h0;
      ready_q <= 1'b0;
    end else if (main_power_on) begin
      hsc_q <= hotswap_severity; // [R3] [R4]
      ready_q <= 1'b1;
    end
  end

  always_comb begin
    sev_deg = sns_q[sild_pkg::SNS_REDUND_LOSS] | sns_q[sild_pkg::SNS_CPU_DISABLED]
      | sns_q[sild_pkg::SNS_FAN_ALARM] | sns_q[sild_pkg::SNS_NONCRIT]
      | sns_q[sild_pkg::SNS_BATTERY] | sns_q[sild_pkg::SNS_PSU_PREDICT]; // [R6]
    sev_deg = sev_deg | (upper_nc_en_q & sns_q[sild_pkg::SNS_UPPER_NC]); // [R11]
    sev_deg = sev_deg | fw_fault_q[sild_pkg::FW_MEM_REDUCED]
      | fw_fault_q[sild_pkg::FW_MIRROR_LOST] | fw_fault_q[sild_pkg::FW_LINK_CORR]; // [R10]
    sev_nf = fw_fault_q[sild_pkg::FW_MEM_CORR_OVER] | fw_fault_q[sild_pkg::FW_LINK_UNCORR]; // [R7]
    sev_nf = sev_nf | sns_q[sild_pkg::SNS_CRIT] | sns_q[sild_pkg::SNS_REG_HOT]
      | sns_q[sild_pkg::SNS_FANS_LOW]; // [R8]
    sev_fatal = sns_q[sild_pkg::SNS_CPU_CATASTROPHIC_ERROR] | sns_q[sild_pkg::SNS_CPU1_ABSENT]
      | sns_q[sild_pkg::SNS_CPU_THERMAL_TRIP] | sns_q[sild_pkg::SNS_NO_PGOOD]
      | sns_q[sild_pkg::SNS_PSU_SHORT] | fw_fault_q[sild_pkg::FW_MEM_NONE]
      | fw_fault_q[sild_pkg::FW_MEM_UNCORR] | fw_fault_q[sild_pkg::FW_CPU_CONFIG]; // [R9]
    // Hot-swap codes 1, 2 and 3 mean degraded, non-fatal and fatal.
    // Highest severity wins regardless of how many lesser faults are present.
    if (sev_fatal || hsc_q == 2'h3) begin
      sev = sild_pkg::SEV_FATAL; // [R1]
    end else if (sev_nf || hsc_q == 2'h2) begin
      sev = sild_pkg::SEV_NONFATAL; // [R1] [R3]
    end else if (sev_deg || hsc_q == 2'h1) begin
      sev = sild_pkg::SEV_DEGRADED;
    end else begin
      sev = sild_pkg::SEV_OK;
    end
  end

  // Status LED stays dark until main power has first come up; afterwards it holds its state.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      status_led_green <= 1'b0;
      status_led_amber <= 1'b0;
    end else if (!ready_q) begin
      status_led_green <= 1'b0; // [R5]
      status_led_amber <= 1'b0;
    end else begin
      case (sev)
        sild_pkg::SEV_OK: begin
          status_led_green <= 1'b1; // [R5]
          status_led_amber <= 1'b0;
        end
        sild_pkg::SEV_DEGRADED: begin
          status_led_green <= blink_phase_q; // [R5] [R16]
          status_led_amber <= 1'b0;
        end
        sild_pkg::SEV_NONFATAL: begin
          status_led_green <= 1'b0; // [R2]
          status_led_amber <= blink_phase_q; // [R5]
        end
        sild_pkg::SEV_FATAL: begin
          status_led_green <= 1'b0; // [R2]
          status_led_amber <= 1'b1; // [R5]
        end
        default: begin
          status_led_green <= 1'b0;
          status_led_amber <= 1'b0;
        end
      endcase
    end
  end

  // Previous button level; only a rising edge counts as a press.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      button_q <= 1'b0;
    end else begin
      button_q <= identify_button;
    end
  end

  assign button_press = identify_button & ~button_q;
  assign cmd_write = wr_pend_q && wr_addr_q == sild_pkg::IDENT_CMD_OFS;

  // The newest request replaces whatever came before; a command beats a press in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      id_q <= sild_pkg::ID_OFF;
    end else if (cmd_write) begin
      if (hwdata[sild_pkg::CMD_ACTIVATE]) begin
        id_q <= sild_pkg::ID_BLINK; // [R13] [R14]
      end else begin
        id_q <= sild_pkg::ID_OFF; // [R13] [R14]
      end
    end else if (button_press) begin
      case (id_q)
        sild_pkg::ID_SOLID: id_q <= sild_pkg::ID_OFF; // [R15]
        sild_pkg::ID_BLINK: id_q <= sild_pkg::ID_SOLID; // [R15] [R14]
        sild_pkg::ID_OFF: id_q <= sild_pkg::ID_SOLID; // [R12]
        default: id_q <= sild_pkg::ID_OFF;
      endcase
    end
  end

  // The identify LED follows the identify state one clock later.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      identify_led <= 1'b0;
    end else begin
      case (id_q)
        sild_pkg::ID_SOLID: identify_led <= 1'b1; // [R12]
        sild_pkg::ID_BLINK: identify_led <= blink_phase_q; // [R13] [R16]
        sild_pkg::ID_OFF: identify_led <= 1'b0; // [R13]
        default: identify_led <= 1'b0;
      endcase
    end
  end

  // Bus slave: never stalls, always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  // Only the lowest 256 bytes decode; anything above reads zero and ignores writes.
  assign addr_low = haddr[31:8] == 24'h000000;

  // The address phase is captured here and acted on in the following data phase.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= wr_take && addr_low;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Firmware fault bits are levels, cleared only when firmware writes them back to zero.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fw_fault_q <= sild_pkg::FW_FAULT_RESET;
      upper_nc_en_q <= sild_pkg::CFG_UPPER_NC_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == sild_pkg::FW_FAULT_OFS) begin
        fw_fault_q <= hwdata[sild_pkg::FW_FAULT_W-1:0]; // [R10]
      end
      if (wr_addr_q == sild_pkg::SENSOR_CFG_OFS) begin
        upper_nc_en_q <= hwdata[sild_pkg::CFG_UPPER_NC_EN]; // [R11]
      end
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    case (haddr[7:0])
      sild_pkg::FW_FAULT_OFS: rd_word = {24'h000000, fw_fault_q};
      sild_pkg::SENSOR_CFG_OFS: rd_word = {31'h00000000, upper_nc_en_q};
      sild_pkg::IDENT_CMD_OFS: rd_word = {30'h00000000, id_q};
      sild_pkg::STATUS_OFS: rd_word = {24'h000000, ready_q, blink_phase_q, identify_led,
        status_led_amber, status_led_green, hsc_q[0], sev};
      sild_pkg::SENSOR_SNAP_OFS: rd_word = {14'h0000, hsc_q, sns_q};
      default: rd_word = 32'h00000000;
    endcase
    if (!addr_low) begin
      rd_word = 32'h00000000;
    end
  end

  // Read data is loaded in the address phase and holds until the next read.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      hrdata <= rd_word;
    end
  end

endmodule : sild_top

// ### verif/sild_top_asserts.sv
`timescale 1ns/1ps
module sild_top_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic main_power_on,
  input wire logic cpu_catastrophic_error,
  input wire logic power_good,
  input wire logic [1:0] hotswap_severity,
  input wire logic status_led_green,
  input wire logic status_led_amber
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_no_mix; !(status_led_green && status_led_amber); endproperty
  a_no_mix: assert property (p_no_mix) else $error("both colors lit");
  property p_cat;
    (main_power_on && cpu_catastrophic_error) [*3] |-> status_led_amber && !status_led_green;
  endproperty
  a_cat: assert property (p_cat) else $error("fatal not amber solid");
  property p_pgood; (main_power_on && !power_good) [*3] |-> status_led_amber; endproperty
  a_pgood: assert property (p_pgood) else $error("power fault not amber");
  property p_hs_fatal;
    (main_power_on && hotswap_severity == 2'h3) [*3] |-> status_led_amber;
  endproperty
  a_hs_fatal: assert property (p_hs_fatal) else $error("neighbour fatal lost");
  property p_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst; $rose(resetn) |-> !status_led_green && !status_led_amber; endproperty
  a_rst: assert property (p_rst) else $error("lit out of reset");
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  c_fatal: cover property (status_led_amber && !status_led_green);
  c_keep: cover property (!main_power_on && status_led_amber);
  c_read: cover property (hsel && htrans[1] && !hwrite);
endmodule : sild_top_chk

bind sild_top sild_top_chk u_chk (.ref_clk, .resetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .main_power_on, .cpu_catastrophic_error, .power_good, .hotswap_severity,
  .status_led_green, .status_led_amber);

// ### verif/sild_src_model.sv
`timescale 1ns/1ps
module sild_src_model (
  input wire logic ref_clk,
  input wire logic [15:0] sns_want,
  input wire logic [1:0] hs_want,
  input wire logic btn_want,
  output logic [15:0] sns = 16'h0,
  output logic [1:0] hs = 2'h0,
  output logic btn = 1'b0
);
  // Sources change just after an edge and hold for whole cycles, as real sensors do.
  always @(posedge ref_clk) begin
    sns <= sns_want;
    hs <= hs_want;
    btn <= btn_want;
  end
endmodule : sild_src_model

// ### verif/tb_status_and_identify_led_control.sv
`timescale 1ns/1ps
module tb_status_and_identify_led_control;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic pwr = 1'b0;
  logic [15:0] sns_w = 16'h0;
  logic [1:0] hs_w = 2'h0;
  logic btn_w = 1'b0;
  logic [15:0] sns;
  logic [1:0] hs;
  logic btn, green, amber, id_led, rdy, resp;
  logic [31:0] hrdata;
  int n_errors = 0;
  int tests_run = 0;
  always #25 ref_clk = ~ref_clk;
  sild_src_model u_src (.ref_clk, .sns_want(sns_w), .hs_want(hs_w), .btn_want(btn_w), .sns,
    .hs, .btn);
  sild_top #(.BLINK_HALF(4)) DUT (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(rdy), .hwdata, .hrdata, .hreadyout(rdy), .hresp(resp),
    .main_power_on(pwr), .redundancy_loss(sns[0]), .cpu_disabled(sns[1]), .fan_alarm(sns[2]),
    .noncrit_threshold(sns[3]), .upper_noncrit_threshold(sns[4]), .battery_fail(sns[5]),
    .psu_predictive_fail(sns[6]), .crit_threshold(sns[7]), .regulator_overtemp(sns[8]),
    .fans_below_min(sns[9]), .cpu_catastrophic_error(sns[10]), .cpu1_absent(sns[11]),
    .cpu_thermal_trip(sns[12]), .power_good(~sns[13]), .psu_insufficient(sns[14]),
    .hotswap_severity(hs), .identify_button(btn), .status_led_green(green),
    .status_led_amber(amber), .identify_led(id_led));
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: bus hang", $time);
      stop_test();
    end
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    ahb(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic t_reset;
    logic [31:0] r;
    chk(32'({amber, green, id_led}), 32'h0, "dark after reset");
    rd(8'h00, r);
    chk(r, 32'h0, "fault reg reset");
    rd(8'h04, r);
    chk(r, 32'h0, "cfg reset");
    rd(8'h0C, r);
    chk(r & 32'hFFFF_FFBF, 32'h0, "status reset");
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, r);
    chk(r, 32'h0, "unmapped");
    wr(8'h00, 32'h0000_00A5);
    rd(8'h00, r);
    chk(r, 32'h0000_00A5, "fault reg rw");
    wr(8'h00, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  function automatic logic [1:0] sev_of(input int i, input logic cfg);
    if (i == 4) return cfg ? 2'h1 : 2'h0;
    if (i < 7) return 2'h1;
    if (i < 10) return 2'h2;
    if (i < 15) return 2'h3;
    return (i == 17) ? 2'h3 : 2'h2;
  endfunction : sev_of
  task automatic t_sources;
    logic [31:0] r;
    logic [1:0] e;
    for (int c = 0; c < 2; c++) begin
      wr(8'h04, 32'(c));
      for (int i = 0; i < 18; i++) begin
        sns_w <= (i < 15) ? (16'h1 << i) : 16'h0080;
        hs_w <= (i < 15) ? 2'h0 : 2'(i - 14);
        cyc(4);
        e = sev_of(i, c[0]);
        rd(8'h0C, r);
        chk(r & 32'h3, 32'(e), "severity");
        if (e == 2'h0 || e == 2'h3) chk(32'({amber, green}), (e == 2'h3) ? 32'h2 : 32'h1,
          "solid color");
        else chk(32'((e == 2'h1) ? amber : green), 32'h0, "blink color");
      end
    end
    sns_w <= 16'h0;
    hs_w <= 2'h0;
    wr(8'h04, 32'h0);
    $display("t_sources done");
  endtask : t_sources
  task automatic t_fw;
    logic [31:0] r;
    for (int i = 0; i < 9; i++) begin
      wr(8'h00, (i < 8) ? (32'h1 << i) : 32'h0);
      cyc(3);
      rd(8'h0C, r);
      chk(r & 32'h3, (i > 7) ? 32'h0 : (i < 3) ? 32'h1 : (i < 5) ? 32'h2 : 32'h3,
        "firmware level");
    end
    $display("t_fw done");
  endtask : t_fw
  task automatic t_retain;
    logic [31:0] r;
    sns_w <= 16'h0400;
    cyc(4);
    pwr <= 1'b0;
    sns_w <= 16'h0;
    cyc(6);
    chk(32'({amber, green}), 32'h2, "fatal kept");
    rd(8'h10, r);
    chk(r & 32'hFFFF, 32'h0400, "sensors kept");
    pwr <= 1'b1;
    cyc(5);
    chk(32'({amber, green}), 32'h1, "ok on power");
    $display("t_retain done");
  endtask : t_retain
  task automatic watch(output int ni, output int same);
    ni = 0;
    same = 0;
    repeat (8) begin
      @(posedge ref_clk);
      ni += int'(id_led === 1'b1);
      same += int'(id_led === green);
    end
  endtask : watch
  task automatic press;
    btn_w <= 1'b1;
    cyc(2);
    btn_w <= 1'b0;
    cyc(4);
  endtask : press
  task automatic t_ident;
    logic [31:0] r;
    int ni;
    int same;
    hs_w <= 2'h1;
    for (int k = 1; k < 4; k += 2) begin
      wr(8'h08, 32'(k));
      cyc(3);
      rd(8'h08, r);
      chk(r & 32'h3, 32'h2, "command blinks");
      watch(ni, same);
      chk(32'(ni), 32'h4, "half duty");
      chk(32'(same), 32'h8, "shared phase");
      press();
      rd(8'h08, r);
      chk(r & 32'h3, 32'h1, "press to solid");
      watch(ni, same);
      chk(32'(ni), 32'h8, "solid on");
      press();
      watch(ni, same);
      chk(32'(ni), 32'h0, "press to off");
    end
    press();
    wr(8'h08, 32'h0);
    cyc(3);
    watch(ni, same);
    chk(32'(ni), 32'h0, "command cancels button");
    hs_w <= 2'h0;
    $display("t_ident done");
  endtask : t_ident
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    pwr <= 1'b1;
    t_sources();
    t_fw();
    t_retain();
    t_ident();
    stop_test();
  end
endmodule : tb_status_and_identify_led_control
